// ==== cas_alu.sv ====
`timescale 1ns/10ps
// Functional notes
// - Flags update after every arithmetic, logic or bit operation except bit load.
// - Register or immediate arithmetic finishes in one clock cycle.
// - Each instruction is one 16-bit or two-word 32-bit form.
// - Application flash write only allowed when executing from boot section.
// - Boot and application sections each have their own write/read locks.
// - Calls and interrupts push the return program counter onto the stack.
// - Lowest vector address pending interrupt is served first.
// - I/O space reached by I/O instructions and data addresses $20-$5F.
// - Extended I/O $60-$FF reachable only through data-space load and store; here an I/O access is accepted at any address.
// - Status register is never saved or restored automatically on interrupts.
// - Status register bit order I,T,H,S,V,N,Z,C, all reset to 0.
// - Interrupt enable clear blocks every interrupt.
// - Taking an interrupt clears enable; interrupt return sets it.
// - Set and clear interrupt instructions write the enable bit.
// - Bit store copies a register bit to T; bit load copies back.
// - Half carry records carry out of the low nibble.
// - Sign equals negative xor overflow.
// - Overflow flags signed two's complement overflow.
// - Negative set on a negative result.
// - Zero set on a zero result.
// - Carry records carry or borrow.
// - Stack pointer drops by two on push of return address, rises on return.
module cas_alu
   import cas_pkg::*;
#(
   parameter int IRQ_COUNT = 8
) (
   // Clock and reset.
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   // Operation from the decoder.
   input  wire cas_pkg::cas_op_type   opCode,
   input  wire logic [7:0]            opA,
   input  wire logic [7:0]            opB,
   input  wire logic [2:0]            bitSel,
   input  wire logic                  opWide,
   // Status register access.
   input  wire cas_pkg::cas_acc_type  accKind,
   input  wire logic [15:0]           accAddr,
   input  wire logic                  accWrite,
   input  wire logic [7:0]            accData,
   // Flow control.
   input  wire cas_pkg::cas_flow_type flowKind,
   input  wire logic [IRQ_COUNT-1:0]  irqPending,
   input  wire logic [15:0]           returnPc,
   // Self-programming checks.
   input  wire logic                  selfProgReq,
   input  wire logic                  pcInBoot,
   input  wire logic                  targetBoot,
   input  wire logic [1:0]            bootLock,
   input  wire logic [1:0]            appLock,
   // Results.
   output logic [7:0]                 result_q,
   output logic                       resultValid_q,
   output logic [7:0]                 statusFlags_q,
   output logic [7:0]                 accReadData_q,
   output logic                       accAllowed_q,
   output logic [15:0]                stackPointer_q,
   output logic [15:0]                pushData_q,
   output logic                       pushValid_q,
   output logic                       irqTake_q,
   output logic [$clog2(IRQ_COUNT)-1:0] irqIndex_q,
   output logic                       selfProgGo_q,
   output logic                       wideInstr_q
);
   import cas_pkg::*;

   logic [7:0]  resultD;
   logic        resultValidD;
   logic [7:0]  flagsD;
   logic [7:0]  accReadD;
   logic        accAllowedD;
   logic [15:0] stkD;
   logic [15:0] pushDataD;
   logic        pushValidD;
   logic        irqTakeD;
   logic [$clog2(IRQ_COUNT)-1:0] irqIndexD;
   logic        selfProgD;
   logic        wideD;
   logic        anyIrq;
   logic [8:0]  sum9;
   logic [4:0]  nib5;
   logic        cin;
   logic        isSub;
   logic        isArith;
   logic        flagOp;
   logic        ioHit;
   logic        statusHit;

   // Priority pick: the lowest index is the lowest vector address.
   always_comb begin
      anyIrq = 1'b0;
      irqIndexD = '0;
      for (int i = IRQ_COUNT - 1; i >= 0; i--) begin
         if (irqPending[i]) begin
            anyIrq = 1'b1;
            irqIndexD = i[$clog2(IRQ_COUNT)-1:0];
         end
      end
   end

   // Arithmetic core, a single combinational pass so results land next edge.
   always_comb begin
      isSub = (opCode == OP_SUB) || (opCode == OP_SBC);
      isArith = isSub || (opCode == OP_ADD) || (opCode == OP_ADC);
      cin = ((opCode == OP_ADC) || (opCode == OP_SBC)) ? statusFlags_q[FLAG_CARRY] : 1'b0;
      if (isSub) begin
         sum9 = {1'b0, opA} - {1'b0, opB} - {8'h00, cin};
         nib5 = {1'b0, opA[3:0]} - {1'b0, opB[3:0]} - {4'h0, cin};
      end else begin
         sum9 = {1'b0, opA} + {1'b0, opB} + {8'h00, cin};
         nib5 = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, cin};
      end
   end

   // Address decode: the status register lives at the top of I/O space.
   always_comb begin
      ioHit = 1'b0;
      statusHit = 1'b0;
      if (accKind == ACC_IO) begin
         ioHit = 1'b1;
         statusHit = (accAddr[5:0] == STATUS_IO_ADDR) && (accAddr[15:6] == 10'h000);
      end else if (accKind == ACC_DATA) begin
         // Data accesses reach I/O and extended I/O, $20-$FF; an I/O form is accepted at any address.
         ioHit = (accAddr >= IO_BASE) && (accAddr <= EXT_IO_LAST);
         statusHit = (accAddr == STATUS_DATA_ADDR);
      end
   end

   // Next state for flags, result, stack and interrupt entry.
   always_comb begin
      flagsD = statusFlags_q;
      resultD = result_q;
      resultValidD = 1'b0;
      stkD = stackPointer_q;
      pushDataD = pushData_q;
      pushValidD = 1'b0;
      irqTakeD = 1'b0;
      accReadD = accReadData_q;
      accAllowedD = ioHit;
      wideD = opWide;
      flagOp = 1'b1;
      case (opCode)
         OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
            resultD = sum9[7:0];
            flagsD[FLAG_CARRY] = sum9[8];
            flagsD[FLAG_HALF] = nib5[4];
            if (isSub) begin
               flagsD[FLAG_OVF] = (opA[7] ^ opB[7]) & (opA[7] ^ sum9[7]);
            end else begin
               flagsD[FLAG_OVF] = ~(opA[7] ^ opB[7]) & (opA[7] ^ sum9[7]);
            end
         end
         OP_AND: begin
            resultD = opA & opB;
            flagsD[FLAG_OVF] = 1'b0;
         end
         OP_OR: begin
            resultD = opA | opB;
            flagsD[FLAG_OVF] = 1'b0;
         end
         OP_XOR: begin
            resultD = opA ^ opB;
            flagsD[FLAG_OVF] = 1'b0;
         end
         OP_PASS: begin
            resultD = opA;
         end
         OP_BITSTORE: begin
            flagsD[FLAG_COPY] = opA[bitSel];
            flagOp = 1'b0;
         end
         OP_BITLOAD: begin
            resultD = opA;
            resultD[bitSel] = statusFlags_q[FLAG_COPY];
            flagOp = 1'b0;
         end
         OP_IRQON: begin
            flagsD[FLAG_IE] = 1'b1;
            flagOp = 1'b0;
         end
         OP_IRQOFF: begin
            flagsD[FLAG_IE] = 1'b0;
            flagOp = 1'b0;
         end
         default: begin
            flagOp = 1'b0;
         end
      endcase
      if (opCode != OP_NONE) begin
         resultValidD = (opCode != OP_IRQON) && (opCode != OP_IRQOFF)
                        && (opCode != OP_BITSTORE);
      end
      // N, Z and S follow every arithmetic and logic operation; pass and bit load leave them.
      if (flagOp && (opCode != OP_PASS)) begin
         flagsD[FLAG_NEG] = resultD[7];
         flagsD[FLAG_ZERO] = (resultD == 8'h00);
         flagsD[FLAG_SIGN] = resultD[7] ^ flagsD[FLAG_OVF];
      end
      // Software access to the status byte; a write overrides the ALU result.
      if (statusHit) begin
         accReadD = statusFlags_q;
         if (accWrite) begin
            flagsD = accData;
         end
      end else if (ioHit) begin
         accReadD = 8'h00;
      end
      // Flow events. The flag byte itself is never pushed or popped.
      case (flowKind)
         FLOW_CALL: begin
            pushDataD = returnPc;
            pushValidD = 1'b1;
            stkD = stackPointer_q - PUSH_STEP;
         end
         FLOW_RET: begin
            stkD = stackPointer_q + PUSH_STEP;
         end
         FLOW_IRQ: begin
            if (statusFlags_q[FLAG_IE] && anyIrq) begin
               irqTakeD = 1'b1;
               pushDataD = returnPc;
               pushValidD = 1'b1;
               stkD = stackPointer_q - PUSH_STEP;
               flagsD[FLAG_IE] = 1'b0;
            end
         end
         FLOW_IRQRET: begin
            stkD = stackPointer_q + PUSH_STEP;
            flagsD[FLAG_IE] = 1'b1;
         end
         default: begin
         end
      endcase
      // Lock bits: bit 0 blocks writes, bit 1 blocks reads and writes.
      selfProgD = selfProgReq && pcInBoot
                  && (targetBoot ? (bootLock == 2'b00) : (appLock == 2'b00));
   end

   // Registers only; reset gives every flag zero.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         result_q       <= 8'h00;
         resultValid_q  <= 1'b0;
         statusFlags_q  <= STATUS_RESET;
         accReadData_q  <= 8'h00;
         accAllowed_q   <= 1'b0;
         stackPointer_q <= STACK_RESET;
         pushData_q     <= 16'h0000;
         pushValid_q    <= 1'b0;
         irqTake_q      <= 1'b0;
         irqIndex_q     <= '0;
         selfProgGo_q   <= 1'b0;
         wideInstr_q    <= 1'b0;
      end else begin
         result_q       <= resultD;
         resultValid_q  <= resultValidD;
         statusFlags_q  <= flagsD;
         accReadData_q  <= accReadD;
         accAllowed_q   <= accAllowedD;
         stackPointer_q <= stkD;
         pushData_q     <= pushDataD;
         pushValid_q    <= pushValidD;
         irqTake_q      <= irqTakeD;
         irqIndex_q     <= irqIndexD;
         selfProgGo_q   <= selfProgD;
         wideInstr_q    <= wideD;
      end
   end

   // Assertions.
   chk_sign_relation: assert property (@(posedge clk) disable iff (!rst_n)
      $changed(statusFlags_q[FLAG_NEG]) |->
      statusFlags_q[FLAG_SIGN] == (statusFlags_q[FLAG_NEG] ^ statusFlags_q[FLAG_OVF]))
      else $error("sign flag not n xor v");
   chk_zero_flag: assert property (@(posedge clk) disable iff (!rst_n)
      (opCode == OP_AND && flowKind == FLOW_NONE && accKind == ACC_NONE) |=>
      statusFlags_q[FLAG_ZERO] == (result_q == 8'h00))
      else $error("zero flag wrong");
   chk_neg_flag: assert property (@(posedge clk) disable iff (!rst_n)
      (opCode == OP_OR && flowKind == FLOW_NONE && accKind == ACC_NONE) |=>
      statusFlags_q[FLAG_NEG] == result_q[7])
      else $error("negative flag wrong");
   chk_add_carry: assert property (@(posedge clk) disable iff (!rst_n)
      (opCode == OP_ADD && accKind == ACC_NONE) |=>
      statusFlags_q[FLAG_CARRY] == ($past(opA) + $past(opB) > 255))
      else $error("carry wrong");
   chk_add_result: assert property (@(posedge clk) disable iff (!rst_n)
      (opCode == OP_ADD) |=> resultValid_q && result_q == 8'($past(opA) + $past(opB)))
      else $error("add result wrong");
   chk_irq_gate: assert property (@(posedge clk) disable iff (!rst_n)
      !statusFlags_q[FLAG_IE] |=> !irqTake_q)
      else $error("irq taken while disabled");
   sequence seq_irq_entry;
      flowKind == FLOW_IRQ && statusFlags_q[FLAG_IE] && |irqPending;
   endsequence
   chk_irq_entry: assert property (@(posedge clk) disable iff (!rst_n)
      seq_irq_entry |=> irqTake_q && !statusFlags_q[FLAG_IE] && pushValid_q
      && stackPointer_q == $past(stackPointer_q) - 16'h0002)
      else $error("irq entry wrong");
   chk_irq_return_instr_ie: assert property (@(posedge clk) disable iff (!rst_n)
      (flowKind == FLOW_IRQRET) |=> statusFlags_q[FLAG_IE])
      else $error("irq_return_instr did not enable");
   chk_bit_store: assert property (@(posedge clk) disable iff (!rst_n)
      (opCode == OP_BITSTORE && accKind == ACC_NONE) |=>
      statusFlags_q[FLAG_COPY] == $past(opA[bitSel]))
      else $error("bit store wrong");
   chk_self_prog: assert property (@(posedge clk) disable iff (!rst_n)
      !pcInBoot |=> !selfProgGo_q)
      else $error("self program outside boot");
   // A call pushes the return address and moves the stack down one word.
   chk_call_push: assert property (@(posedge clk) disable iff (!rst_n)
      (flowKind == FLOW_CALL) |=> pushValid_q && pushData_q == $past(returnPc)
      && stackPointer_q == $past(stackPointer_q) - 16'h0002)
      else $error("call push wrong");
   // A plain return moves the stack back up one word.
   chk_ret_pop: assert property (@(posedge clk) disable iff (!rst_n)
      (flowKind == FLOW_RET) |=> stackPointer_q == $past(stackPointer_q) + 16'h0002)
      else $error("return pop wrong");
   // Enable and disable instructions, with no competing flow event or software write.
   chk_irq_on: assert property (@(posedge clk) disable iff (!rst_n)
      (opCode == OP_IRQON && flowKind == FLOW_NONE && accKind == ACC_NONE) |=>
      statusFlags_q[FLAG_IE])
      else $error("enable instruction failed");
   chk_irq_off: assert property (@(posedge clk) disable iff (!rst_n)
      (opCode == OP_IRQOFF && flowKind == FLOW_NONE && accKind == ACC_NONE) |=>
      !statusFlags_q[FLAG_IE])
      else $error("disable instruction failed");
   // A locked application section refuses a write even from the boot section.
   chk_lock_deny: assert property (@(posedge clk) disable iff (!rst_n)
      (selfProgReq && !targetBoot && appLock != 2'b00) |=> !selfProgGo_q)
      else $error("locked section written");
   // Data addresses beyond the extended range are not I/O.
   chk_io_range: assert property (@(posedge clk) disable iff (!rst_n)
      (accKind == ACC_DATA && accAddr > 16'h00ff) |=> !accAllowed_q)
      else $error("io range wrong");
   // Bit load places the copy bit at the selected position.
   chk_bit_load: assert property (@(posedge clk) disable iff (!rst_n)
      (opCode == OP_BITLOAD) |=> result_q[$past(bitSel)] == $past(statusFlags_q[FLAG_COPY]))
      else $error("bit load wrong");
endmodule

// ==== cas_decoder_model.sv ====
`timescale 1ns/10ps
// Stands in for the instruction decoder and register file that feed the ALU.
module cas_decoder_model
   import cas_pkg::*;
(
   // Clock.
   input  wire logic                  clk,
   // Decoder outputs toward the ALU.
   output cas_pkg::cas_op_type        opCode,
   output logic [7:0]                 opA,
   output logic [7:0]                 opB,
   output logic [2:0]                 bitSel,
   output logic                       opWide,
   output cas_pkg::cas_acc_type       accKind,
   output logic [15:0]                accAddr,
   output logic                       accWrite,
   output logic [7:0]                 accData,
   output cas_pkg::cas_flow_type      flowKind,
   output logic [7:0]                 irqPending,
   output logic [15:0]                returnPc,
   output logic                       selfProgReq,
   output logic                       pcInBoot,
   output logic                       targetBoot,
   output logic [1:0]                 bootLock,
   output logic [1:0]                 appLock
);
   // Everything idles at time zero so the ALU never sees an unknown request.
   initial begin
      {opA, opB, bitSel, opWide, accAddr, accWrite, accData} = '0;
      {irqPending, returnPc, selfProgReq, pcInBoot, targetBoot, bootLock, appLock} = '0;
      opCode = OP_NONE;
      accKind = ACC_NONE;
      flowKind = FLOW_NONE;
   end
   // A request stands for exactly one edge, then the strobes drop back to idle.
   task automatic fin;
      @(posedge clk);
      opCode <= OP_NONE;
      opWide <= 1'b0;
      accKind <= ACC_NONE;
      accWrite <= 1'b0;
      flowKind <= FLOW_NONE;
      selfProgReq <= 1'b0;
   endtask
   // One ALU or bit operation.
   task automatic exec(cas_op_type o, logic [7:0] a, logic [7:0] b, logic [2:0] s, logic w);
      @(posedge clk);
      opCode <= o;
      opA <= a;
      opB <= b;
      bitSel <= s;
      opWide <= w;
      fin();
   endtask
   // One status register access through the IO or data space.
   task automatic acc(cas_acc_type k, logic [15:0] ad, logic wr, logic [7:0] d);
      @(posedge clk);
      accKind <= k;
      accAddr <= ad;
      accWrite <= wr;
      accData <= d;
      fin();
   endtask
   // One flow event; pending lines are held afterwards, as a real source would.
   task automatic flow(cas_flow_type k, logic [7:0] pend, logic [15:0] pc);
      @(posedge clk);
      flowKind <= k;
      irqPending <= pend;
      returnPc <= pc;
      fin();
   endtask
   // One self-programming write attempt.
   task automatic prog(logic inBoot, logic tgt, logic [1:0] bl, logic [1:0] al);
      @(posedge clk);
      selfProgReq <= 1'b1;
      pcInBoot <= inBoot;
      targetBoot <= tgt;
      bootLock <= bl;
      appLock <= al;
      fin();
   endtask
endmodule

// ==== cas_pkg.sv ====
package cas_pkg;
   // Status flag bit positions.
   localparam int FLAG_IE    = 7;
   localparam int FLAG_COPY  = 6;
   localparam int FLAG_HALF  = 5;
   localparam int FLAG_SIGN  = 4;
   localparam int FLAG_OVF   = 3;
   localparam int FLAG_NEG   = 2;
   localparam int FLAG_ZERO  = 1;
   localparam int FLAG_CARRY = 0;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   // Address map of the data space.
   localparam logic [15:0] IO_BASE     = 16'h0020;
   localparam logic [15:0] IO_LAST     = 16'h005f;
   localparam logic [15:0] EXT_IO_LAST = 16'h00ff;
   localparam logic [15:0] STATUS_DATA_ADDR = 16'h005f;
   localparam logic [5:0]  STATUS_IO_ADDR   = 6'h3f;
   localparam logic [15:0] STACK_RESET      = 16'h0000;
   localparam logic [15:0] PUSH_STEP  = 16'h0002;
   // Operations.
   typedef enum logic [3:0] {
      OP_NONE, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR,
      OP_BITSTORE, OP_BITLOAD, OP_IRQON, OP_IRQOFF, OP_PASS
   } cas_op_type;
   // Address space access kinds.
   typedef enum logic [1:0] {
      ACC_NONE, ACC_IO, ACC_DATA
   } cas_acc_type;
   // Flow events affecting the stack and enable bit.
   typedef enum logic [2:0] {
      FLOW_NONE, FLOW_CALL, FLOW_RET, FLOW_IRQ, FLOW_IRQRET
   } cas_flow_type;
endpackage

// ==== cpu_alu_status_flags_tb.sv ====
`timescale 1ns/10ps
module cpu_alu_status_flags_tb;
   import cas_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   int mismatches = 0;
   int checks = 0;
   int cycles = 0;
   cas_op_type opCode;
   cas_acc_type accKind;
   cas_flow_type flowKind;
   logic [7:0] opA, opB, accData, irqPending, result_q, statusFlags_q, accReadData_q;
   logic [2:0] bitSel, irqIndex_q;
   logic [15:0] accAddr, returnPc, stackPointer_q, pushData_q;
   logic [1:0] bootLock, appLock;
   logic opWide, accWrite, selfProgReq, pcInBoot, targetBoot, resultValid_q, accAllowed_q;
   logic pushValid_q, irqTake_q, selfProgGo_q, wideInstr_q;
   // The clock toggles every half period of 25 ns.
   always #25 clk = ~clk;
   cas_decoder_model p (.clk(clk), .opCode(opCode), .opA(opA), .opB(opB), .bitSel(bitSel),
      .opWide(opWide), .accKind(accKind), .accAddr(accAddr), .accWrite(accWrite),
      .accData(accData), .flowKind(flowKind), .irqPending(irqPending), .returnPc(returnPc),
      .selfProgReq(selfProgReq), .pcInBoot(pcInBoot), .targetBoot(targetBoot),
      .bootLock(bootLock), .appLock(appLock));
   cas_alu #(.IRQ_COUNT(8)) DUT (.clk(clk), .rst_n(rst_n), .opCode(opCode), .opA(opA),
      .opB(opB), .bitSel(bitSel), .opWide(opWide), .accKind(accKind), .accAddr(accAddr),
      .accWrite(accWrite), .accData(accData), .flowKind(flowKind), .irqPending(irqPending),
      .returnPc(returnPc), .selfProgReq(selfProgReq), .pcInBoot(pcInBoot),
      .targetBoot(targetBoot), .bootLock(bootLock), .appLock(appLock), .result_q(result_q),
      .resultValid_q(resultValid_q), .statusFlags_q(statusFlags_q),
      .accReadData_q(accReadData_q), .accAllowed_q(accAllowed_q),
      .stackPointer_q(stackPointer_q), .pushData_q(pushData_q), .pushValid_q(pushValid_q),
      .irqTake_q(irqTake_q), .irqIndex_q(irqIndex_q), .selfProgGo_q(selfProgGo_q),
      .wideInstr_q(wideInstr_q));
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Four-state compare, so an unknown output never counts as a match.
   task automatic chk(logic [15:0] got, logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Runs one operation and compares the result and the masked flags a moment later.
   task automatic alu(cas_op_type o, logic [7:0] a, b, r, f, m);
      p.exec(o, a, b, 3'h0, 1'b0);
      #1;
      chk({8'h00, result_q}, {8'h00, r});
      chk({15'h0000, resultValid_q}, 16'h0001);
      chk({8'h00, statusFlags_q & m}, {8'h00, f & m});
   endtask
   task automatic t_arith;
      alu(OP_ADD, 8'h0f, 8'h01, 8'h10, 8'h20, 8'hff);
      alu(OP_ADD, 8'h7f, 8'h01, 8'h80, 8'h2c, 8'hff);
      alu(OP_ADD, 8'hff, 8'h01, 8'h00, 8'h23, 8'hff);
      alu(OP_SUB, 8'h00, 8'h01, 8'hff, 8'h35, 8'hff);
      alu(OP_AND, 8'hf0, 8'h0f, 8'h00, 8'h02, 8'h1e);
      alu(OP_OR, 8'h80, 8'h00, 8'h80, 8'h14, 8'h1e);
      alu(OP_XOR, 8'h0f, 8'h0f, 8'h00, 8'h02, 8'h1e);
   endtask
   // The status register is written by IO number and read back by data address.
   task automatic t_access;
      p.acc(ACC_IO, 16'h003f, 1'b1, 8'h15);
      #1;
      chk({15'h0000, accAllowed_q}, 16'h0001);
      chk({8'h00, statusFlags_q}, 16'h0015);
      p.acc(ACC_DATA, 16'h005f, 1'b0, 8'h00);
      #1;
      chk({8'h00, accReadData_q}, 16'h0015);
      p.acc(ACC_DATA, 16'h0060, 1'b0, 8'h00);
      #1;
      chk({15'h0000, accAllowed_q}, 16'h0001);
      p.acc(ACC_DATA, 16'h0100, 1'b0, 8'h00);
      #1;
      chk({15'h0000, accAllowed_q}, 16'h0000);
   endtask
   // Enable, take, refuse and return; the low flag bits must ride through untouched.
   task automatic t_flow;
      p.exec(OP_IRQON, 8'h00, 8'h00, 3'h0, 1'b0);
      #1;
      chk({8'h00, statusFlags_q}, 16'h0095);
      p.flow(FLOW_IRQ, 8'b00000110, 16'h1234);
      #1;
      chk({15'h0000, irqTake_q}, 16'h0001);
      chk({13'h0000, irqIndex_q}, 16'h0001);
      chk({15'h0000, pushValid_q}, 16'h0001);
      chk(pushData_q, 16'h1234);
      chk(stackPointer_q, 16'hfffe);
      chk({8'h00, statusFlags_q}, 16'h0015);
      p.flow(FLOW_IRQ, 8'b00000110, 16'h1234);
      #1;
      chk({15'h0000, irqTake_q}, 16'h0000);
      p.flow(FLOW_IRQRET, 8'h00, 16'h0000);
      #1;
      chk({8'h00, statusFlags_q}, 16'h0095);
      chk(stackPointer_q, 16'h0000);
      p.exec(OP_IRQOFF, 8'h00, 8'h00, 3'h0, 1'b0);
      p.flow(FLOW_CALL, 8'h00, 16'h0abc);
      #1;
      chk({8'h00, statusFlags_q}, 16'h0015);
      chk(pushData_q, 16'h0abc);
      chk(stackPointer_q, 16'hfffe);
      p.flow(FLOW_RET, 8'h00, 16'h0000);
      #1;
      chk(stackPointer_q, 16'h0000);
   endtask
   // Bit copy, wide instruction marking and self-programming permission.
   task automatic t_misc;
      p.exec(OP_BITSTORE, 8'h40, 8'h00, 3'h6, 1'b0);
      #1;
      chk({15'h0000, statusFlags_q[FLAG_COPY]}, 16'h0001);
      p.exec(OP_BITLOAD, 8'h00, 8'h00, 3'h3, 1'b1);
      #1;
      chk({8'h00, result_q}, 16'h0008);
      chk({15'h0000, wideInstr_q}, 16'h0001);
      p.prog(1'b1, 1'b0, 2'b00, 2'b00);
      #1;
      chk({15'h0000, selfProgGo_q}, 16'h0001);
      p.prog(1'b0, 1'b0, 2'b00, 2'b00);
      #1;
      chk({15'h0000, selfProgGo_q}, 16'h0000);
      p.prog(1'b1, 1'b0, 2'b00, 2'b01);
      #1;
      chk({15'h0000, selfProgGo_q}, 16'h0000);
      p.prog(1'b1, 1'b1, 2'b10, 2'b00);
      #1;
      chk({15'h0000, selfProgGo_q}, 16'h0000);
   endtask
   // A hang is cut short well beyond the 64 or so cycles the run needs.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         mismatches++;
         conclude();
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk({8'h00, statusFlags_q}, 16'h0000);
      t_arith();
      t_access();
      t_flow();
      t_misc();
      conclude();
   end
endmodule
